// *** rtl/ccpcu_compare_unit.sv ***
// compare unit: match register, pin latch, special event trigger, pwm latch
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`include "ccpcu_map.svh"

module ccpcu_compare_unit #(
  parameter int UNIT = 1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] timer_a_count,
  input  wire logic [15:0] timer_b_count,
  input  wire logic [7:0]  timer_b_control,
  input  wire logic [7:0]  pwm_timer_count,
  input  wire logic [1:0]  pwm_q_count,
  input  wire logic        pwm_period_hit,
  input  wire logic        adc_enable,
  input  wire logic        port_data_latch,
  input  wire logic        port_direction_reg,
  output logic             unit_output_pin,
  output logic             unit_output_oe,
  output logic             special_trigger,
  output logic             timer_a_reset,
  output logic             timer_b_reset,
  output logic             adc_start,
  output logic             timer_flag_block,
  output logic             irq
);
  import ccpcu_pkg::*;

  ccpcu_unit_t st_r;
  ccpcu_unit_t st_nxt;
  ccpcu_wr_t   wr;
  ccpcu_rd_t   rd;
  logic [7:0]  rd_data;
  logic [3:0]  mode;
  logic        is_compare;
  logic        is_pwm;
  logic        drives_pin;
  logic        has_trig;
  logic        hit;
  logic        use_b;
  logic        cmp_hit;
  logic        trig_hit;
  logic [1:0]  ev;
  logic [1:0]  rd_clr;
  logic [9:0]  new_duty;
  logic [7:0]  wr_mode_ctrl;

  ccpcu_axil_slave u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr            (wr),
    .rd            (rd),
    .rd_data       (rd_data)
  );

  ccpcu_match_det #(
    .UNIT (UNIT)
  ) u_det (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .enable        (is_compare),
    .match_value   ({st_r.match_hi, st_r.match_lo}),
    .timer_a_count (timer_a_count),
    .timer_b_count (timer_b_count),
    .timer_sel     ({timer_b_control[`CCPCU_TSEL_HI_BIT],
                     timer_b_control[`CCPCU_TSEL_LO_BIT]}),
    .use_b         (use_b),
    .hit           (hit)
  );

  // register read mux; reserved control bits 7:6 read as zero
  always_comb begin
    rd_data = 8'h00;
    if (rd.addr == `CCPCU_OFS_MATCH_LO) rd_data = st_r.match_lo;
    else if (rd.addr == `CCPCU_OFS_MATCH_HI) rd_data = st_r.match_hi;
    else if (rd.addr == `CCPCU_OFS_CTRL) rd_data = {2'b00, st_r.ctrl};
    else if (rd.addr == `CCPCU_OFS_STATUS) rd_data = {6'h00, st_r.status};
    else if (rd.addr == `CCPCU_OFS_MASK) rd_data = {6'h00, st_r.mask};
    else if (rd.addr == `CCPCU_OFS_PINST)
      rd_data = {4'h0, st_r.pin_oe, st_r.pin_o, st_r.pwm_latch,
                 st_r.cmp_latch};
  end

  always_comb begin
    st_nxt       = st_r;
    mode         = st_r.ctrl[`CCPCU_MODE_MSB:`CCPCU_MODE_LSB];
    is_pwm       = (mode[3:2] == 2'b11);
    is_compare   = (mode == CCPCU_TOGGLE) || (mode == CCPCU_SET_HI) ||
                   (mode == CCPCU_SET_LO) || (mode == CCPCU_SWINT) ||
                   (mode == CCPCU_SPECIAL);
    drives_pin   = (mode == CCPCU_TOGGLE) || (mode == CCPCU_SET_HI) ||
                   (mode == CCPCU_SET_LO) || is_pwm;
    // units 3 to 5 fall back to software interrupt behaviour
    has_trig     = (UNIT <= `CCPCU_TRIG_UNITS);
    cmp_hit      = hit && is_compare;
    trig_hit     = cmp_hit && (mode == CCPCU_SPECIAL) && has_trig;
    new_duty     = {st_r.match_lo,
                    st_r.ctrl[`CCPCU_DUTY_MSB:`CCPCU_DUTY_LSB]};
    wr_mode_ctrl = wr.data;

    // pin action on a match event
    if (cmp_hit) begin
      if (mode == CCPCU_SET_HI) st_nxt.cmp_latch = 1'b1;
      else if (mode == CCPCU_SET_LO) st_nxt.cmp_latch = 1'b0;
      else if (mode == CCPCU_TOGGLE)
        st_nxt.cmp_latch = !st_r.cmp_latch;
      // software interrupt and special codes leave the latch alone
    end

    // the special trigger resets only the timer pair the unit compares on
    st_nxt.trig      = trig_hit;
    st_nxt.ta_rst    = trig_hit && !use_b;
    st_nxt.tb_rst    = trig_hit && use_b;
    st_nxt.adc_go    = trig_hit && (UNIT == `CCPCU_ADC_UNIT) &&
                       adc_enable;
    st_nxt.tflag_blk = trig_hit && (UNIT == `CCPCU_ADC_UNIT);

    // pwm: duty is double buffered and taken at each period restart
    // a duty beyond the period never clears the latch, by design
    if (is_pwm) begin
      if (pwm_period_hit) begin
        st_nxt.duty      = new_duty;
        st_nxt.match_hi  = st_r.match_lo;
        st_nxt.pwm_latch = (new_duty != 10'h000);
      end else if ({pwm_timer_count, pwm_q_count} == st_r.duty) begin
        st_nxt.pwm_latch = 1'b0;
      end
    end

    // register writes; match high is read-only while in pwm mode
    if (wr.en) begin
      if (wr.addr == `CCPCU_OFS_MATCH_LO) st_nxt.match_lo = wr.data;
      else if (wr.addr == `CCPCU_OFS_MATCH_HI) begin
        if (!is_pwm) st_nxt.match_hi = wr.data;
      end else if (wr.addr == `CCPCU_OFS_CTRL) begin
        st_nxt.ctrl = wr.data[5:0];
        if (wr.data == 8'h00) begin
          st_nxt.cmp_latch = 1'b0;
          st_nxt.pwm_latch = 1'b0;
        end else if (wr_mode_ctrl[3:0] == CCPCU_SET_HI) begin
          st_nxt.cmp_latch = 1'b0;
        end else if (wr_mode_ctrl[3:0] == CCPCU_SET_LO) begin
          st_nxt.cmp_latch = 1'b1;
        end
      end else if (wr.addr == `CCPCU_OFS_MASK) st_nxt.mask = wr.data[1:0];
    end

    // sticky events; a read clears them but an event in that cycle wins
    ev[`CCPCU_ST_MATCH] = cmp_hit;
    ev[`CCPCU_ST_TRIG]  = trig_hit;
    rd_clr = {2{rd.en && (rd.addr == `CCPCU_OFS_STATUS)}};
    for (int i = 0; i < 2; i++) begin
      if (ev[i]) st_nxt.status[i] = 1'b1;
      else if (rd_clr[i]) st_nxt.status[i] = 1'b0;
    end

    // port data drives the pin unless a compare or pwm mode owns it
    st_nxt.pin_o  = !drives_pin ? port_data_latch :
                    is_pwm ? st_nxt.pwm_latch : st_nxt.cmp_latch;
    st_nxt.pin_oe = !port_direction_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r          <= '0;
      st_r.ctrl     <= `CCPCU_CTRL_RST;
      st_r.match_lo <= `CCPCU_MATCH_RST;
      st_r.match_hi <= `CCPCU_MATCH_RST;
      st_r.mask     <= `CCPCU_MASK_RST;
      st_r.status   <= `CCPCU_STATUS_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign unit_output_pin  = st_r.pin_o;
  assign unit_output_oe   = st_r.pin_oe;
  assign special_trigger  = st_r.trig;
  assign timer_a_reset    = st_r.ta_rst;
  assign timer_b_reset    = st_r.tb_rst;
  assign adc_start        = st_r.adc_go;
  assign timer_flag_block = st_r.tflag_blk;
  assign irq              = |(st_r.status & st_r.mask);

  // a control write of zero, set-high or set-low in the match cycle wins over the pin action,
  // so the pin properties skip that cycle
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence special_match_s;
    hit && st_r.ctrl[3:0] == CCPCU_SPECIAL && UNIT <= `CCPCU_TRIG_UNITS;
  endsequence

  sequence trig_pulse_s;
    special_trigger && (timer_a_reset != timer_b_reset) ##1 !special_trigger;
  endsequence

  match_flag_set_a: assert property (
    hit && is_compare |=> st_r.status[`CCPCU_ST_MATCH])
    else $error("match did not set the flag");

  force_high_a: assert property (
    hit && mode == CCPCU_SET_HI && !wr.en |=> st_r.cmp_latch ##1
    unit_output_pin || !drives_pin)
    else $error("set-high mode did not raise the pin");

  force_low_a: assert property (
    hit && mode == CCPCU_SET_LO && !wr.en |=> !st_r.cmp_latch)
    else $error("set-low mode did not clear the latch");

  toggle_pin_a: assert property (
    hit && mode == CCPCU_TOGGLE && !wr.en |=>
    st_r.cmp_latch != $past(st_r.cmp_latch))
    else $error("toggle mode did not invert the latch");

  swint_pin_kept_a: assert property (
    hit && mode == CCPCU_SWINT && !wr.en |=>
    $stable(st_r.cmp_latch) && st_r.status[`CCPCU_ST_MATCH] && !special_trigger)
    else $error("software interrupt mode touched the pin");

  ctrl_clear_a: assert property (
    wr.en && wr.addr == `CCPCU_OFS_CTRL && wr.data == 8'h00 |=>
    !st_r.cmp_latch && !st_r.pwm_latch ##1
    unit_output_pin == $past(port_data_latch))
    else $error("clearing control left a latch high");

  trig_reset_a: assert property (
    special_match_s |=> trig_pulse_s and
    (timer_b_reset == $past(use_b)))
    else $error("special trigger did not reset the selected timer");

  adc_start_a: assert property (
    special_trigger |-> adc_start ==
    (UNIT == `CCPCU_ADC_UNIT && $past(adc_enable)))
    else $error("conversion start does not follow the unit 2 trigger");

  no_trig_high_a: assert property (
    UNIT > `CCPCU_TRIG_UNITS |-> !special_trigger && !timer_a_reset &&
    !timer_b_reset)
    else $error("units 3 to 5 must not trigger");

  flag_block_a: assert property (
    (timer_a_reset || timer_b_reset) |-> timer_flag_block ==
    (UNIT == `CCPCU_ADC_UNIT))
    else $error("timer flag suppression wrong");

  pwm_period_a: assert property (
    is_pwm && pwm_period_hit && !wr.en |=>
    st_r.pwm_latch == (st_r.duty != 10'h000))
    else $error("pwm latch not set at period restart");

  preset_low_a: assert property (
    wr.en && wr.addr == `CCPCU_OFS_CTRL && wr.data[3:0] == CCPCU_SET_HI
    |=> !st_r.cmp_latch)
    else $error("set-high mode did not preset the latch low");

  preset_high_a: assert property (
    wr.en && wr.addr == `CCPCU_OFS_CTRL && wr.data[3:0] == CCPCU_SET_LO
    |=> st_r.cmp_latch)
    else $error("set-low mode did not preset the latch high");

  status_clear_a: assert property (
    rd.en && rd.addr == `CCPCU_OFS_STATUS && !cmp_hit && !trig_hit
    |=> st_r.status == 2'b00)
    else $error("status read did not clear the flags");

  trig_flag_a: assert property (
    special_match_s |=>
    st_r.status[`CCPCU_ST_TRIG] && special_trigger)
    else $error("special trigger did not set its status bit");

  special_latch_a: assert property (
    hit && mode == CCPCU_SPECIAL && !wr.en |=>
    $stable(st_r.cmp_latch))
    else $error("special trigger mode touched the compare latch");

  pwm_buffer_a: assert property (
    is_pwm && pwm_period_hit |=>
    st_r.match_hi == $past(st_r.match_lo))
    else $error("duty not copied into match high at period restart");

  pwm_duty_end_a: assert property (
    is_pwm && !pwm_period_hit && !wr.en &&
    {pwm_timer_count, pwm_q_count} == st_r.duty |=> !st_r.pwm_latch)
    else $error("pwm latch not cleared at the duty match");

  adc_gate_a: assert property (
    adc_start || timer_flag_block |-> special_trigger)
    else $error("conversion start or flag block without a trigger");

endmodule

// *** rtl/ccpcu_map.svh ***
// register offsets, field positions and reset values of the compare unit
`ifndef CCPCU_MAP_SVH
`define CCPCU_MAP_SVH

// byte offsets on the register bus, one aligned word each
`define CCPCU_OFS_MATCH_LO 8'h00
`define CCPCU_OFS_MATCH_HI 8'h04
`define CCPCU_OFS_CTRL     8'h08
`define CCPCU_OFS_STATUS   8'h0C
`define CCPCU_OFS_MASK     8'h10
`define CCPCU_OFS_PINST    8'h14

// reset values
`define CCPCU_CTRL_RST     6'h00
`define CCPCU_MATCH_RST    8'h00
`define CCPCU_MASK_RST     2'h0
`define CCPCU_STATUS_RST   2'h0

// unit control fields
`define CCPCU_MODE_LSB     0
`define CCPCU_MODE_MSB     3
`define CCPCU_DUTY_LSB     4
`define CCPCU_DUTY_MSB     5

// status and mask bits
`define CCPCU_ST_MATCH     0
`define CCPCU_ST_TRIG      1

// timer-to-unit enable bits inside the timer_b_control register
`define CCPCU_TSEL_LO_BIT  3
`define CCPCU_TSEL_HI_BIT  6

// units that own a special event trigger, and the unit that starts the adc
`define CCPCU_TRIG_UNITS   2
`define CCPCU_ADC_UNIT     2

// bus responses
`define CCPCU_RESP_OKAY    2'b00
`define CCPCU_RESP_SLVERR  2'b10

`endif

// *** rtl/ccpcu_pkg.sv ***
// types and shared decoders of the compare unit
`include "ccpcu_map.svh"
package ccpcu_pkg;

  typedef enum logic [3:0] {
    CCPCU_OFF     = 4'b0000,
    CCPCU_TOGGLE  = 4'b0010,
    CCPCU_SET_HI  = 4'b1000,
    CCPCU_SET_LO  = 4'b1001,
    CCPCU_SWINT   = 4'b1010,
    CCPCU_SPECIAL = 4'b1011
  } ccpcu_mode_t;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } ccpcu_wr_t;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
  } ccpcu_rd_t;

  typedef struct packed {
    logic       aw_held;
    logic [7:0] awaddr;
    logic       w_held;
    logic [7:0] wdata;
    logic       wlane0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } ccpcu_slv_t;

  typedef struct packed {
    logic eq_prev;
  } ccpcu_det_t;

  typedef struct packed {
    logic [7:0] match_lo;
    logic [7:0] match_hi;
    logic [5:0] ctrl;
    logic [1:0] mask;
    logic [1:0] status;
    logic       cmp_latch;
    logic       pwm_latch;
    logic [9:0] duty;
    logic       pin_o;
    logic       pin_oe;
    logic       trig;
    logic       ta_rst;
    logic       tb_rst;
    logic       adc_go;
    logic       tflag_blk;
  } ccpcu_unit_t;

  // true when the unit compares against timer b
  function automatic logic ccpcu_use_timer_b(input logic [1:0] tsel,
                                             input int unit);
    logic r;
    r = 1'b0;
    case (tsel)
      2'b00: r = 1'b0;
      2'b01: r = (unit != 1);
      2'b10: r = (unit > 2);
      default: r = 1'b1;
    endcase
    return r;
  endfunction

  function automatic logic ccpcu_addr_ok(input logic [7:0] a);
    logic r;
    r = 1'b0;
    if (a == `CCPCU_OFS_MATCH_LO) r = 1'b1;
    else if (a == `CCPCU_OFS_MATCH_HI) r = 1'b1;
    else if (a == `CCPCU_OFS_CTRL) r = 1'b1;
    else if (a == `CCPCU_OFS_STATUS) r = 1'b1;
    else if (a == `CCPCU_OFS_MASK) r = 1'b1;
    else if (a == `CCPCU_OFS_PINST) r = 1'b1;
    return r;
  endfunction

endpackage

// *** rtl/ccpcu_axil_slave.sv ***
// axi4-lite slave front end: one write and one read at a time
`include "ccpcu_map.svh"
module ccpcu_axil_slave (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output ccpcu_pkg::ccpcu_wr_t    wr,
  output ccpcu_pkg::ccpcu_rd_t    rd,
  input  wire logic [7:0]         rd_data
);
  import ccpcu_pkg::*;

  ccpcu_slv_t st_r;
  ccpcu_slv_t st_nxt;
  logic       both_held;

  always_comb begin
    st_nxt        = st_r;
    both_held     = st_r.aw_held && st_r.w_held && !st_r.bvalid;
    s_axi_awready = !st_r.aw_held && !st_r.bvalid;
    s_axi_wready  = !st_r.w_held && !st_r.bvalid;
    s_axi_arready = !st_r.rvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata  = s_axi_wdata[7:0];
      st_nxt.wlane0 = s_axi_wstrb[0];
    end
    // registers are eight bits wide, so only byte lane 0 writes
    wr.en   = both_held && ccpcu_addr_ok(st_r.awaddr) && st_r.wlane0;
    wr.addr = st_r.awaddr;
    wr.data = st_r.wdata;
    if (both_held) begin
      st_nxt.bvalid  = 1'b1;
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.bresp   = ccpcu_addr_ok(st_r.awaddr) ? `CCPCU_RESP_OKAY
                                                  : `CCPCU_RESP_SLVERR;
    end
    if (st_r.bvalid && s_axi_bready) st_nxt.bvalid = 1'b0;
    // unmapped reads have no side effect and answer slverr
    rd.en   = s_axi_arvalid && s_axi_arready && ccpcu_addr_ok(s_axi_araddr);
    rd.addr = s_axi_araddr;
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd.en ? rd_data : 8'h00;
      st_nxt.rresp  = rd.en ? `CCPCU_RESP_OKAY : `CCPCU_RESP_SLVERR;
    end
    if (st_r.rvalid && s_axi_rready) st_nxt.rvalid = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) st_r <= '0;
    else st_r <= st_nxt;
  end

  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp  = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp  = st_r.rresp;
  assign s_axi_rdata  = {24'h000000, st_r.rdata};

endmodule

// *** rtl/ccpcu_match_det.sv ***
// equality detector on the selected timer pair, one hit per match event
`include "ccpcu_map.svh"
module ccpcu_match_det #(
  parameter int UNIT = 1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        enable,
  input  wire logic [15:0] match_value,
  input  wire logic [15:0] timer_a_count,
  input  wire logic [15:0] timer_b_count,
  input  wire logic [1:0]  timer_sel,
  output logic             use_b,
  output logic             hit
);
  import ccpcu_pkg::*;

  ccpcu_det_t  st_r;
  ccpcu_det_t  st_nxt;
  logic [15:0] count;
  logic        eq;

  always_comb begin
    use_b  = ccpcu_use_timer_b(timer_sel, UNIT);
    count  = use_b ? timer_b_count : timer_a_count;
    eq     = enable && (count == match_value);
    // only the rising side of equality counts as a match event
    hit    = eq && !st_r.eq_prev;
    st_nxt.eq_prev = eq;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) st_r <= '0;
    else st_r <= st_nxt;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  hit_on_equal_a: assert property (hit |-> count == match_value)
    else $error("hit without equality on the selected timer");
  single_hit_a: assert property (hit ##1 eq |-> !hit)
    else $error("second hit while values stay equal");

endmodule

// *** verification/ccpcu_pin_partner.sv ***
// board circuit on the compare pin: port bits, direction, pulled-down wire
module ccpcu_pin_partner #(
  parameter logic PORT_LEVEL = 1'b1
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic unit_output_pin,
  input  wire logic unit_output_oe,
  output logic      port_data_latch,
  output logic      port_direction_reg,
  output logic      pin_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // software turns the pin to output only once reset is over
  always @(posedge aclk) port_direction_reg <= !aresetn;
  assign port_data_latch = PORT_LEVEL;
  // pull-down keeps an undriven pin from reading as a stale level
  assign pin_wire = unit_output_oe ? unit_output_pin : 1'b0;
endmodule

// *** verification/tb.sv ***
// self-checking bench of the compare unit, built as unit 2
`include "ccpcu_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ccpcu_pkg::*;
  localparam logic PORT_LVL = 1'b1;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, timer_b_control;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, tsel;
  logic [15:0] timer_a_count, timer_b_count, mv;
  logic        adc_enable, port_data_latch, port_direction_reg, pin_wire;
  logic        unit_output_pin, unit_output_oe, special_trigger, irq;
  logic        timer_a_reset, timer_b_reset, adc_start, timer_flag_block;
  int          miscompares, n_compared, cyc;
  logic [31:0] cnt[5];
  logic [7:0]  pwm_timer_count;
  logic [1:0]  pwm_q_count;
  logic        pwm_period_hit;
  ccpcu_mode_t modes[4];

  ccpcu_compare_unit #(.UNIT(2)) u_ccpcu_compare_unit (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .timer_a_count, .timer_b_count,
    .timer_b_control, .pwm_timer_count, .pwm_q_count,
    .pwm_period_hit, .adc_enable, .port_data_latch,
    .port_direction_reg, .unit_output_pin, .unit_output_oe,
    .special_trigger, .timer_a_reset, .timer_b_reset, .adc_start,
    .timer_flag_block, .irq
  );
  ccpcu_pin_partner #(.PORT_LEVEL(PORT_LVL)) u_ccpcu_pin_partner (
    .aclk, .aresetn, .unit_output_pin, .unit_output_oe,
    .port_data_latch, .port_direction_reg, .pin_wire
  );

  always #2.5 aclk = ~aclk;

  always @(posedge aclk) begin
    cnt[0] += special_trigger;
    cnt[1] += timer_a_reset;
    cnt[2] += timer_b_reset;
    cnt[3] += adc_start;
    cnt[4] += timer_flag_block;
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er = `CCPCU_RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask

  task automatic axr(input logic [7:0] a, input logic [7:0] ed,
                     input logic [1:0] er = `CCPCU_RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h000000, ed});
    chk(s_axi_rresp, er);
  endtask

  function automatic logic exp_pin(input ccpcu_mode_t m, input logic post);
    case (m)
      CCPCU_SET_HI, CCPCU_TOGGLE: return post;
      CCPCU_SET_LO: return !post;
      default: return PORT_LVL;
    endcase
  endfunction

  task automatic set_match();
    axw(`CCPCU_OFS_CTRL, 8'h00);
    axw(`CCPCU_OFS_MATCH_LO, mv[7:0]);
    axw(`CCPCU_OFS_MATCH_HI, mv[15:8]);
  endtask

  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, adc_enable} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {timer_a_count, timer_b_count, timer_b_control} = '0;
    {pwm_timer_count, pwm_q_count, pwm_period_hit} = '0;
    modes = '{CCPCU_SET_HI, CCPCU_SET_LO, CCPCU_TOGGLE, CCPCU_SWINT};
    void'($urandom(27));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) axr(8'(4 * i), 8'h00);
    axr(8'h18, 8'h00, `CCPCU_RESP_SLVERR);
    axw(8'h18, 8'hFF, `CCPCU_RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      mv = 16'($urandom);
      tsel = 2'($urandom);
      timer_b_control <= {1'b0, tsel[1], 2'b00, tsel[0], 3'b000};
      timer_a_count <= ~mv;
      timer_b_count <= ~mv;
      axw(`CCPCU_OFS_MASK, {7'h00, i[0]});
      set_match();
      axr(`CCPCU_OFS_PINST, 8'h0C);
      axw(`CCPCU_OFS_CTRL, {4'h0, modes[i]});
      axr(`CCPCU_OFS_STATUS, 8'h00);
      // the timer not chosen reaches the value first and must not count
      @(posedge aclk);
      if (tsel[0]) timer_a_count <= mv;
      else timer_b_count <= mv;
      repeat (4) @(negedge aclk);
      chk(pin_wire, exp_pin(modes[i], 1'b0));
      @(posedge aclk);
      if (tsel[0]) timer_b_count <= mv;
      else timer_a_count <= mv;
      repeat (8) @(negedge aclk);
      chk(pin_wire, exp_pin(modes[i], 1'b1));
      chk(irq, i[0]);
      axr(`CCPCU_OFS_PINST, {4'h0, 1'b1, exp_pin(modes[i], 1'b1), 1'b0,
          (modes[i] != CCPCU_SWINT) && exp_pin(modes[i], 1'b1)});
      axr(`CCPCU_OFS_STATUS, 8'h01);
      axr(`CCPCU_OFS_STATUS, 8'h00);
      @(negedge aclk);
      chk(irq, 1'b0);
      if (modes[i] == CCPCU_TOGGLE) begin
        @(posedge aclk);
        {timer_a_count, timer_b_count} <= {~mv, ~mv};
        @(posedge aclk);
        {timer_a_count, timer_b_count} <= {mv, mv};
        repeat (4) @(negedge aclk);
        chk(pin_wire, 1'b0);
        axr(`CCPCU_OFS_STATUS, 8'h01);
      end
    end
    for (int k = 0; k < 2; k++) begin
      mv = 16'($urandom);
      @(posedge aclk);
      timer_b_control <= (k == 0) ? 8'h08 : 8'h00;
      adc_enable <= (k == 0);
      {timer_a_count, timer_b_count} <= {~mv, ~mv};
      set_match();
      axw(`CCPCU_OFS_CTRL, {4'h0, CCPCU_SPECIAL});
      axr(`CCPCU_OFS_STATUS, 8'h00);
      @(negedge aclk);
      cnt = '{default: 0};
      @(posedge aclk);
      if (k == 1) timer_a_count <= mv;
      else timer_b_count <= mv;
      repeat (8) @(negedge aclk);
      chk(cnt[0], 1);
      chk(cnt[1], k);
      chk(cnt[2], 1 - k);
      chk(cnt[3], 1 - k);
      chk(cnt[4], 1);
      axr(`CCPCU_OFS_STATUS, 8'h03);
    end
    // pwm: duty taken at each restart, latch cleared at the duty match
    mv = 16'($urandom) | 16'h0001;
    set_match();
    axw(`CCPCU_OFS_CTRL, {2'b00, mv[9:8], 4'hC});
    for (int p = 0; p < 2; p++) begin
      @(posedge aclk);
      pwm_period_hit <= 1'b1;
      {pwm_timer_count, pwm_q_count} <= 10'h000;
      @(posedge aclk);
      pwm_period_hit <= 1'b0;
      axr(`CCPCU_OFS_PINST, 8'h0E);
      axr(`CCPCU_OFS_MATCH_HI, mv[7:0]);
      if (p == 0) begin
        @(posedge aclk);
        {pwm_timer_count, pwm_q_count} <= {mv[7:0], mv[9:8]};
        axr(`CCPCU_OFS_PINST, 8'h08);
      end
    end
    axw(`CCPCU_OFS_CTRL, 8'h00);
    axr(`CCPCU_OFS_PINST, 8'h0C);
    end_sim();
  end
endmodule
